// file: verilog/sec_pkg.sv
// shared constants and types for the soft error checker
package sec_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned ROW_W   = 8;
  localparam int unsigned CRC_W   = 17;
  localparam int unsigned RUN_W   = 25;
  localparam int unsigned SYNC_W  = 16;

  // ----------------------------------------------------------------
  // timing counts, in sys_clk cycles, and the width of their counter
  // ----------------------------------------------------------------
  localparam int unsigned LAUNCH_CYCLES = 11;
  localparam int unsigned BLIND_CYCLES  = 14;
  localparam int unsigned CNT_W         = 4;

  // in-progress lengths for the smallest and largest arrays
  localparam int unsigned RUN_CYCLES_MIN = 4423344;
  localparam int unsigned RUN_CYCLES_MAX = 30613424;

  // row count of the smallest array (rows 0..45)
  localparam int unsigned ROWS_MIN = 46;

  // ----------------------------------------------------------------
  // stream constants
  // ----------------------------------------------------------------
  // serial crc generator polynomial, implicit top term
  localparam logic [CRC_W-1:0]  CRC_POLY  = 17'h1002D;
  localparam logic [CRC_W-1:0]  CRC_INIT  = 17'h00000;
  // start sequence marking the first analysed bit of the readback
  localparam logic [SYNC_W-1:0] SYNC_WORD = 16'hA5C3;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    SEC_IDLE   = 5'h01,
    SEC_LAUNCH = 5'h02,
    SEC_SYNC   = 5'h04,
    SEC_RUN    = 5'h08,
    SEC_BLIND  = 5'h10
  } sec_state_t;

endpackage : sec_pkg

// file: verilog/sec_crc17.sv
// serial 17-bit crc engine, one bit per enabled cycle
`timescale 1ns/1ns
`default_nettype none

module sec_crc17 (
  input  wire logic                     sys_clk,
  input  wire logic                     rstn,
  input  wire logic                     en,
  input  wire logic                     din,
  input  wire logic                     clr,
  output logic [sec_pkg::CRC_W-1:0]     crc,
  output logic [sec_pkg::CRC_W-1:0]     crc_next
);

  logic fb;

  // ----------------------------------------------------------------
  // next value including the current bit
  // ----------------------------------------------------------------
  always_comb begin
    fb       = crc[sec_pkg::CRC_W-1] ^ din;
    crc_next = {crc[sec_pkg::CRC_W-2:0], 1'b0} ^ (fb ? sec_pkg::CRC_POLY : '0);
  end

  // ----------------------------------------------------------------
  // register; clear wins so a new segment starts from the seed
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      crc <= sec_pkg::CRC_INIT;
    end else if (clr) begin
      crc <= sec_pkg::CRC_INIT;
    end else if (en) begin
      crc <= crc_next;
    end
  end

endmodule : sec_crc17

`default_nettype wire

// file: verilog/sec_checker.sv
// configuration memory soft error checker: sequencer, row crc check, error report
`timescale 1ns/1ns
`default_nettype none

module sec_checker #(
  // array geometry; must match the array the checker runs on
  parameter int unsigned RUN_CYCLES = sec_pkg::RUN_CYCLES_MIN,
  parameter int unsigned NUM_ROWS   = sec_pkg::ROWS_MIN
) (
  input  wire logic                       sys_clk,
  input  wire logic                       rstn,
  input  wire logic                       start,
  input  wire logic                       frc_err,
  input  wire logic [sec_pkg::ROW_W-1:0]  frc_row,
  input  wire logic                       rb_bit,
  input  wire logic [sec_pkg::CRC_W-1:0]  exp_crc,
  output logic                            rb_req,
  output logic [sec_pkg::ROW_W-1:0]       exp_row,
  output logic                            data_out,
  output logic                            start_out,
  output logic                            in_prog,
  output logic                            done,
  output logic                            err,
  output logic [sec_pkg::ROW_W-1:0]       err_row,
  output logic [sec_pkg::ROW_W-1:0]       err_cnt
);

  // ----------------------------------------------------------------
  // derived geometry
  // ----------------------------------------------------------------
  // the last row takes the remainder of the fixed run length
  localparam int unsigned SEG_CYCLES = RUN_CYCLES / NUM_ROWS;
  localparam logic [sec_pkg::RUN_W-1:0] RUN_LAST = sec_pkg::RUN_W'(RUN_CYCLES - 1);
  localparam logic [sec_pkg::RUN_W-1:0] SEG_LAST = sec_pkg::RUN_W'(SEG_CYCLES - 1);
  localparam logic [sec_pkg::ROW_W-1:0] ROW_LAST = sec_pkg::ROW_W'(NUM_ROWS - 1);
  localparam logic [sec_pkg::CNT_W-1:0] LAUNCH_LAST =
    sec_pkg::CNT_W'(sec_pkg::LAUNCH_CYCLES - 1);
  localparam logic [sec_pkg::CNT_W-1:0] BLIND_LAST =
    sec_pkg::CNT_W'(sec_pkg::BLIND_CYCLES - 1);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  sec_pkg::sec_state_t                state;
  logic [sec_pkg::CNT_W-1:0]          seq_cnt;
  logic [sec_pkg::RUN_W-1:0]          run_cnt;
  logic [sec_pkg::RUN_W-1:0]          seg_cnt;
  logic [sec_pkg::ROW_W-1:0]          row;
  logic [sec_pkg::SYNC_W-1:0]         sync_sh;
  logic                               accept;
  logic                               sync_hit;
  logic                               run_end;
  logic                               seg_end;
  logic                               inject;
  logic                               ana_bit;
  logic                               mismatch;
  logic [sec_pkg::CRC_W-1:0]          crc;
  logic [sec_pkg::CRC_W-1:0]          crc_next;

  // ----------------------------------------------------------------
  // combinational decode
  // ----------------------------------------------------------------
  // start is looked at only in idle, which excludes the run and blind spans
  assign accept   = (state == sec_pkg::SEC_IDLE) && start;
  assign sync_hit = (state == sec_pkg::SEC_SYNC) &&
                    ({sync_sh[sec_pkg::SYNC_W-2:0], rb_bit} == sec_pkg::SYNC_WORD);
  assign run_end  = (state == sec_pkg::SEC_RUN) && (run_cnt == RUN_LAST);
  assign seg_end  = (state == sec_pkg::SEC_RUN) &&
                    (run_end || ((seg_cnt == SEG_LAST) && (row != ROW_LAST)));

  // one flipped bit at the head of the chosen row; out-of-range rows never match
  assign inject   = frc_err && (state == sec_pkg::SEC_RUN) && (seg_cnt == '0) &&
                    (frc_row == row) && (frc_row <= ROW_LAST);
  // only the analysed copy is altered; the array itself is read, never written
  assign ana_bit  = rb_bit ^ inject;
  assign mismatch = seg_end && (crc_next != exp_crc);
  assign exp_row  = row;
  assign rb_req   = (state == sec_pkg::SEC_SYNC) || (state == sec_pkg::SEC_RUN);

  // ----------------------------------------------------------------
  // row crc engine
  // ----------------------------------------------------------------
  sec_crc17 u_crc (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .en       (state == sec_pkg::SEC_RUN),
    .din      (ana_bit),
    .clr      (seg_end || accept),
    .crc      (crc),
    .crc_next (crc_next)
  );

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state   <= sec_pkg::SEC_IDLE;
      seq_cnt <= '0;
    end else begin
      case (state)
        sec_pkg::SEC_IDLE: begin
          seq_cnt <= '0;
          if (accept) begin
            state <= sec_pkg::SEC_LAUNCH;
          end
        end
        sec_pkg::SEC_LAUNCH: begin
          seq_cnt <= seq_cnt + 1'b1;
          if (seq_cnt == LAUNCH_LAST) begin
            state   <= sec_pkg::SEC_SYNC;
            seq_cnt <= '0;
          end
        end
        sec_pkg::SEC_SYNC: begin
          if (sync_hit) begin
            state <= sec_pkg::SEC_RUN;
          end
        end
        sec_pkg::SEC_RUN: begin
          if (run_end) begin
            state   <= sec_pkg::SEC_BLIND;
            seq_cnt <= '0;
          end
        end
        sec_pkg::SEC_BLIND: begin
          seq_cnt <= seq_cnt + 1'b1;
          if (seq_cnt == BLIND_LAST) begin
            state <= sec_pkg::SEC_IDLE;
          end
        end
        default: begin
          state   <= sec_pkg::SEC_IDLE;
          seq_cnt <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      start_out <= 1'b0;
      in_prog   <= 1'b0;
      done      <= 1'b0;
    end else begin
      if (state == sec_pkg::SEC_LAUNCH && seq_cnt == LAUNCH_LAST) begin
        start_out <= 1'b1;
      end else if (run_end) begin
        start_out <= 1'b0;
      end
      if (sync_hit) begin
        in_prog <= 1'b1;
      end else if (run_end) begin
        in_prog <= 1'b0;
      end
      if (run_end) begin
        done <= 1'b1;
      end else if (accept) begin
        done <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // stream position: sync shifter, run, segment and row counters
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync_sh <= '0;
      run_cnt <= '0;
      seg_cnt <= '0;
      row     <= '0;
    end else begin
      if (state == sec_pkg::SEC_SYNC) begin
        sync_sh <= {sync_sh[sec_pkg::SYNC_W-2:0], rb_bit};
      end else begin
        sync_sh <= '0;
      end
      if (state == sec_pkg::SEC_RUN) begin
        run_cnt <= run_cnt + 1'b1;
        if (seg_end) begin
          seg_cnt <= '0;
          row     <= row + 1'b1;
        end else begin
          seg_cnt <= seg_cnt + 1'b1;
        end
      end else begin
        run_cnt <= '0;
        seg_cnt <= '0;
        row     <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // analysed stream out
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      data_out <= 1'b0;
    end else if (state == sec_pkg::SEC_RUN) begin
      data_out <= ana_bit;
    end else begin
      data_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // error report; rows arrive in rising order so the first is lowest
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      err     <= 1'b0;
      err_row <= '0;
      err_cnt <= '0;
    end else if (accept) begin
      err     <= 1'b0;
      err_row <= '0;
      err_cnt <= '0;
    end else if (mismatch) begin
      err     <= 1'b1;
      if (!err) begin
        err_row <= row;
      end
      // saturates rather than wrapping past 255 rows
      if (err_cnt != '1) begin
        err_cnt <= err_cnt + 1'b1;
      end
    end
  end

endmodule : sec_checker

`default_nettype wire

// file: dv/sec_rb_model.sv
// readback stream source and expected row crc table for the checker
`timescale 1ns/1ns
`default_nettype none

module sec_rb_model #(
  parameter int SEG = 10
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rb_req,
  input  wire logic [7:0]            exp_row,
  input  wire logic [7:0]            flip_row,
  output logic                       rb_bit,
  output logic [sec_pkg::CRC_W-1:0]  exp_crc
);
  int   idx = 0;
  logic tgl = 1'b0;

  function automatic logic dbit(input int k);
    return k[0] ^ k[2];
  endfunction : dbit

  function automatic logic [16:0] seg_crc(input int r);
    logic [16:0] c;
    logic        fb;
    c = 17'h00000;
    for (int k = r * SEG; k < (r + 1) * SEG; k++) begin
      fb = c[16] ^ dbit(k);
      c = {c[15:0], 1'b0} ^ (fb ? sec_pkg::CRC_POLY : 17'h00000);
    end
    return c;
  endfunction : seg_crc

  // table built from clean data; the upset lives only in the stream
  assign exp_crc = seg_crc(exp_row);

  // idle line toggles so a stale bit is never mistaken for data
  always_comb begin
    if (!rb_req)
      rb_bit = tgl;
    else if (idx < 16)
      rb_bit = sec_pkg::SYNC_WORD[15-idx];
    else
      rb_bit = dbit(idx - 16) ^ ((idx - 16) == flip_row * SEG + 5);
  end

  always @(posedge sys_clk) begin
    tgl <= ~tgl;
    idx <= rb_req ? idx + 1 : 0;
  end
endmodule : sec_rb_model
`default_nettype wire

// file: dv/sec_checker_chk.sv
// port assertions for the soft error checker
`timescale 1ns/1ns
`default_nettype none

module sec_checker_chk #(
  parameter int unsigned RUN_CYCLES = 40
) (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        start,
  input wire logic        rb_bit,
  input wire logic        rb_req,
  input wire logic        start_out,
  input wire logic        in_prog,
  input wire logic        done,
  input wire logic        err,
  input wire logic [7:0]  err_row,
  input wire logic [7:0]  err_cnt
);
  logic [15:0] sh;
  int unsigned run_n;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      sh <= 16'h0000;
    else
      sh <= {sh[14:0], rb_bit};
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn)
      run_n <= 0;
    else
      run_n <= in_prog ? run_n + 1 : 0;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  AST_LAUNCH_DELAY: assert property ($fell(done) |-> !start_out [*8] ##1 !start_out [*3] ##1 $rose(start_out))
    else $error("launch not eleven cycles after accept");
  AST_LAUNCH_CAUSE: assert property ($rose(start_out) |-> $past(start, 12))
    else $error("launch without a start request");
  AST_SYNC_DETECT: assert property ((rb_req && !in_prog && {sh[14:0], rb_bit} == sec_pkg::SYNC_WORD) |=> in_prog)
    else $error("start sequence missed");
  AST_RUN_HOLD: assert property (in_prog |-> start_out)
    else $error("launch dropped during run");
  AST_RUN_END: assert property ($fell(in_prog) |-> $fell(start_out) && done && run_n == RUN_CYCLES)
    else $error("run length or end flags wrong");
  AST_BLIND: assert property ($rose(done) |-> done [*8] ##1 done [*7])
    else $error("start taken inside blind window");
  AST_DONE_HOLD: assert property (done && !start |=> done)
    else $error("done dropped without start");
  AST_REPORT_HOLD: assert property (done && $past(done) |-> $stable(err) && $stable(err_row) && $stable(err_cnt))
    else $error("report changed while done");
  AST_CLEAR: assert property ($fell(done) |-> !err && err_row == 8'h00 && err_cnt == 8'h00)
    else $error("report not cleared on accept");
  AST_ERR_CNT: assert property (done |-> err == (err_cnt != 8'h00))
    else $error("error flag disagrees with count");
endmodule : sec_checker_chk

bind sec_checker sec_checker_chk #(.RUN_CYCLES(RUN_CYCLES)) u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .start(start), .rb_bit(rb_bit), .rb_req(rb_req),
  .start_out(start_out), .in_prog(in_prog), .done(done), .err(err),
  .err_row(err_row), .err_cnt(err_cnt));
`default_nettype wire

// file: dv/sec_checker_test.sv
// self-checking testbench for the soft error checker
`timescale 1ns/1ns
`default_nettype none

module sec_checker_test;
  localparam int RUN  = 40;
  localparam int ROWS = 4;
  logic        sys_clk  = 1'b0;
  logic        rstn     = 1'b0;
  logic        start    = 1'b0;
  logic        frc_err  = 1'b0;
  logic [7:0]  frc_row  = 8'h00;
  logic [7:0]  flip_row = 8'hFF;
  logic        rb_bit, rb_req, data_out, start_out, in_prog, done, err, done_q;
  logic [16:0] exp_crc;
  logic [7:0]  exp_row, err_row, err_cnt;
  logic [16:0] notes[$];
  int          fail_count = 0;
  int          checks = 0;
  int          seed = 32'h55CD;
  logic        run_q    = 1'b0;
  logic        bit_q    = 1'b0;
  logic        want_bit = 1'b0;
  int          bit_n    = 0;

  always #5 sys_clk = ~sys_clk;

  sec_checker #(.RUN_CYCLES(RUN), .NUM_ROWS(ROWS)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .start(start), .frc_err(frc_err), .frc_row(frc_row),
    .rb_bit(rb_bit), .exp_crc(exp_crc), .rb_req(rb_req), .exp_row(exp_row),
    .data_out(data_out), .start_out(start_out), .in_prog(in_prog), .done(done),
    .err(err), .err_row(err_row), .err_cnt(err_cnt));

  sec_rb_model #(.SEG(RUN / ROWS)) u_rb (
    .sys_clk(sys_clk), .rb_req(rb_req), .exp_row(exp_row), .flip_row(flip_row),
    .rb_bit(rb_bit), .exp_crc(exp_crc));

  task automatic compare(input logic [16:0] seen, input logic [16:0] want);
    checks++;
    if (seen !== want) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : compare

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wait_done();
    int t;
    t = 0;
    while (!in_prog && t < 60) begin
      @(negedge sys_clk);
      t++;
    end
    while (in_prog && t < RUN + 80) begin
      @(negedge sys_clk);
      t++;
    end
  endtask : wait_done

  // f/r drive the forced error, u upsets a streamed bit in row u
  task automatic analyse(input logic f, input logic [7:0] r, input logic [7:0] u);
    logic [7:0] first;
    logic [7:0] n;
    first = 8'h00;
    n = 8'h00;
    for (int k = ROWS - 1; k >= 0; k--) begin
      if (k == u || (f && k == r)) begin
        first = k[7:0];
        n++;
      end
    end
    notes.push_back({n != 8'h00, first, n});
    // stay clear of the blind span that follows the previous done
    repeat (15) @(negedge sys_clk);
    frc_err = f;
    frc_row = r;
    flip_row = u;
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    wait_done();
  endtask : analyse

  always @(negedge sys_clk) begin
    if (done && !done_q) begin
      if (notes.size() == 0)
        compare(17'h1FFFF, 17'h00000);
      else
        compare({err, err_row, err_cnt}, notes.pop_front());
    end
    done_q <= done;
  end

  // analysed stream lags readback by one clock; head bit of a forced row is flipped
  always @(negedge sys_clk) begin
    want_bit = bit_q ^ (frc_err && frc_row < ROWS && bit_n == frc_row * (RUN / ROWS));
    if (rstn)
      compare({16'h0000, data_out}, {16'h0000, run_q && want_bit});
    run_q <= in_prog;
    bit_q <= rb_bit;
    bit_n <= run_q ? bit_n + 1 : 0;
  end

  initial begin
    repeat (5) @(negedge sys_clk);
    rstn = 1'b1;
    fork
      analyse(1'b0, 8'h00, 8'hFF);
      begin
        repeat (45) @(negedge sys_clk);
        start = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
      end
    join
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    repeat (25) @(negedge sys_clk);
    compare({14'h0000, start_out, in_prog, done}, 17'h00001);
    analyse(1'b1, 8'h03, 8'h01);
    analyse(1'b1, 8'h04, 8'hFF);
    for (int i = 0; i < 6; i++)
      analyse(1'b1, 8'($unsigned($random(seed)) % 6), 8'($unsigned($random(seed)) % 5));
    notes.push_back(17'h10201);
    notes.push_back(17'h10201);
    frc_err = 1'b1;
    frc_row = 8'h02;
    flip_row = 8'hFF;
    start = 1'b1;
    wait_done();
    wait_done();
    // reset inside the blind span, while done and the report are still set
    repeat (10) @(negedge sys_clk);
    rstn = 1'b0;
    start = 1'b0;
    @(negedge sys_clk);
    compare({err, err_row, err_cnt}, 17'h00000);
    compare({13'h0000, start_out, in_prog, done, rb_req}, 17'h00000);
    rstn = 1'b1;
    analyse(1'b1, 8'h00, 8'h00);
    repeat (20) @(negedge sys_clk);
    compare(17'(notes.size()), 17'h00000);
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    fail_count++;
    tally_and_finish();
  end
endmodule : sec_checker_test
`default_nettype wire
